// file: src/nand_mgmt_pkg.sv
// Constants and types shared by the flash block-management controller
package nand_mgmt_pkg;

   // ************************************************************
   // Flash command bytes
   // ************************************************************
   localparam logic [7:0] CMD_READ1  = 8'h00;
   localparam logic [7:0] CMD_READ2  = 8'h30;
   localparam logic [7:0] CMD_PROG1  = 8'h80;
   localparam logic [7:0] CMD_PROG2  = 8'h10;
   localparam logic [7:0] CMD_ERASE1 = 8'h60;
   localparam logic [7:0] CMD_ERASE2 = 8'hD0;
   localparam logic [7:0] CMD_STATUS = 8'h70;

   // ************************************************************
   // Data values, fields and limits
   // ************************************************************
   localparam logic [7:0] BAD_MARK        = 8'h00;
   localparam logic [7:0] PAD_BYTE        = 8'hFF;
   localparam int         STATUS_FAIL_BIT = 0;
   localparam logic [2:0] ADDR_FIRST_FULL = 3'h0;
   localparam logic [2:0] ADDR_FIRST_ROW  = 3'h2;
   localparam logic [2:0] ADDR_LAST       = 3'h4;
   localparam logic [2:0] MAX_PARTIAL     = 3'h4;
   localparam int         SEG_BITS        = 2;
   localparam int         BLOCKS_MAX       = 1024;
   localparam int         BLOCKS_MIN_VALID = 1004;
   localparam int         MAX_RETIRED      = BLOCKS_MAX - BLOCKS_MIN_VALID;
   localparam int         ECC_UNIT_BYTES   = 512;
   localparam int         ECC_CORRECT_BITS = 8;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_WB_NS       = 100;
   localparam int WB_CYCLES     = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE, OP_SCAN} op_kind_type;

endpackage

// file: src/nand_block_manager.sv
// Host-side flash sequencer with bad-block, partial-program and order policing
//
// Datasheet rules this block is built around
// [RQ1] At most four partial programs per page
// [RQ2] Bytes outside written segment are sent as ones
// [RQ3] Never erase a block marked bad
// [RQ4] Scan all blocks before any other access
// [RQ5] Device marks every page of bad block
// [RQ6] Scan reads one byte; 00h means bad
// [RQ7] Bad blocks recorded and excluded from access
// [RQ8] Up to twenty retired blocks are tolerated
// [RQ9] Erase status fail retires the block
// [RQ10] Program fail: reload data into another block
// [RQ11] Program-failed block added to bad table
// [RQ12] Read data protected by 8-bit/512-byte ECC
// [RQ13] Watch corrected count, advise rewrite early
// [RQ14] Correctable errors alone never retire blocks
// [RQ15] Spread program/erase wear across blocks
// [RQ16] Pad unused page areas with ones
// [RQ17] Status read is 70h then one read
// [RQ18] Status bit zero: zero pass, one fail
// [RQ19] Pages in a block programmed ascending
// [RQ20] Check block against bad table first
module nand_block_manager
   import nand_mgmt_pkg::*;
#(
   parameter int NUM_BLOCKS = BLOCKS_MAX,
   parameter int PAGE_BITS  = 6,
   parameter int PAGE_BYTES = 2048,
   parameter int STROBE_DIV = 4,
   parameter int ECC_WARN   = 6
) (
   input  logic                      sys_clk,
   input  logic                      rst_n,
   input  logic                      opValid,
   output logic                      opReady,
   input  op_kind_type               opKind,
   input  logic [$clog2(NUM_BLOCKS)-1:0] opBlock,
   input  logic [PAGE_BITS-1:0]      opPage,
   input  logic                      opPartial,
   input  logic [SEG_BITS-1:0]       opSegment,
   input  logic [7:0]                wrData,
   input  logic                      wrValid,
   output logic                      wrReady,
   output logic [7:0]                rdData,
   output logic                      rdValid,
   output logic                      rdUnitEnd,
   input  logic                      eccValid,
   input  logic [3:0]                eccCorrected,
   output logic                      rewriteAdvice,
   output logic                      doneValid,
   output logic                      doneFail,
   output logic                      doneReject,
   output logic                      reloadReq,
   output logic [$clog2(NUM_BLOCKS)-1:0] spareBlock,
   output logic                      scanDone,
   output logic [$clog2(NUM_BLOCKS):0] badCount,
   output logic                      wornOut,
   output logic                      nandCeN,
   output logic                      nandCle,
   output logic                      nandAle,
   output logic                      nandWeN,
   output logic                      nandReN,
   output logic                      nandWpN,
   output logic [7:0]                nandIoOut,
   output logic                      nandIoOe,
   input  logic [7:0]                nandIoIn,
   input  logic                      nandReadyBusy
);

   localparam int BB = $clog2(NUM_BLOCKS);
   localparam int BC = $clog2(PAGE_BYTES);
   localparam int DW = $clog2(STROBE_DIV);
   localparam int UB = $clog2(ECC_UNIT_BYTES);
   localparam logic [BB-1:0] LAST_BLOCK = BB'(NUM_BLOCKS - 1);
   localparam logic [BC-1:0] LAST_BYTE  = BC'(PAGE_BYTES - 1);
   localparam logic [15:0]   MARK_COL   = 16'(PAGE_BYTES);
   // Busy pin reaches rbReady only after the three-flop sync, so wait it out
   localparam int            SYNC_LAG   = 4;
   // Pages smaller than an ECC unit end a unit on their last byte
   localparam int            UW         = (UB < BC) ? UB : BC;

   typedef enum {sIdle, sCmd, sAddr, sWrite, sCmd2, sWaitB, sWaitR, sStCmd, sStRead,
                 sRead, sSpare, sDone} state_type;

   function automatic logic [7:0] addrByte(input logic [2:0] idx, input logic [15:0] col,
                                           input logic [23:0] row);
      case (idx)
         3'h0: addrByte = col[7:0];
         3'h1: addrByte = col[15:8];
         3'h2: addrByte = row[7:0];
         3'h3: addrByte = row[15:8];
         default: addrByte = row[23:16];
      endcase
   endfunction

   state_type              state;
   op_kind_type            curKind;
   logic [BB-1:0]          curBlock;
   logic [PAGE_BITS-1:0]   curPage;
   logic                   curPartial;
   logic [SEG_BITS-1:0]    curSeg;
   logic [2:0]             addrIdx;
   logic [BC-1:0]          byteCnt;
   logic [7:0]             waitCnt;
   logic [BB-1:0]          searchCnt;
   logic [DW-1:0]          divCnt;
   logic                   phase;
   logic [7:0]             ioS1, ioS2, ioS3;
   logic                   rbS1, rbS2, rbS3, rbReady;
   logic [NUM_BLOCKS-1:0]  badMap;
   logic [NUM_BLOCKS-1:0]  usedMap;
   logic [PAGE_BITS-1:0]   lastPage [NUM_BLOCKS];
   logic [2:0]             partCnt  [NUM_BLOCKS];

   // ************************************************************
   // Decode and strobe timing
   // ************************************************************
   wire tick      = (divCnt == DW'(STROBE_DIV - 1));
   wire writing   = state inside {sCmd, sAddr, sWrite, sCmd2, sStCmd};
   wire reading   = state inside {sRead, sStRead};
   wire inSeg     = !curPartial || (byteCnt[BC-1 -: SEG_BITS] == curSeg);
   wire ioSettled = (ioS2 == ioS3);
   wire stall     = (state == sWrite && inSeg && !wrValid && !phase)
                  || (reading && phase && !ioSettled);
   wire step      = tick && (writing || reading) && !stall;
   wire cycleEnd  = step && phase;
   wire isScan    = (curKind == OP_SCAN);
   wire isProg    = (curKind == OP_PROGRAM);
   wire [15:0] col = isScan ? MARK_COL : 16'h0000;
   wire [23:0] row = 24'({curBlock, curPage});
   wire [7:0] cmdFirst  = (curKind == OP_PROGRAM) ? CMD_PROG1 :
                          (curKind == OP_ERASE) ? CMD_ERASE1 : CMD_READ1;
   wire [7:0] cmdSecond = (curKind == OP_PROGRAM) ? CMD_PROG2 :
                          (curKind == OP_ERASE) ? CMD_ERASE2 : CMD_READ2;
   wire [7:0] nextIo = (state == sCmd)   ? cmdFirst :
                       (state == sAddr)  ? addrByte(addrIdx, col, row) :
                       (state == sWrite) ? (inSeg ? wrData : PAD_BYTE) :  // see [RQ2] [RQ16]
                       (state == sCmd2)  ? cmdSecond : CMD_STATUS;        // see [RQ17]

   // ************************************************************
   // Request screening against the block tables
   // ************************************************************
   wire accept    = opValid && opReady;
   wire sameUsed  = usedMap[opBlock];
   wire orderBad  = sameUsed && (opPage < lastPage[opBlock]                  // see [RQ19]
                  || (opPage == lastPage[opBlock] && partCnt[opBlock] >= MAX_PARTIAL)); // see [RQ1]
   wire rejectOp  = (opKind != OP_SCAN && (!scanDone || badMap[opBlock]))   // see [RQ4] [RQ20]
                  || (opKind == OP_PROGRAM && orderBad);
   wire statFail  = (state == sStRead) && cycleEnd && ioS3[STATUS_FAIL_BIT];  // see [RQ18]
   wire scanBad   = (state == sRead) && cycleEnd && isScan && ioS3 == BAD_MARK; // see [RQ6]
   wire markBad   = statFail || scanBad;                           // see [RQ9] [RQ11]
   wire spareOk   = !badMap[spareBlock] && !usedMap[spareBlock] && spareBlock != curBlock;
   wire eraseOk   = (state == sStRead) && cycleEnd && !statFail && curKind == OP_ERASE;

   assign opReady = (state == sIdle);
   assign wrReady = (state == sWrite) && inSeg && step && !phase;
   assign nandCeN = (state == sIdle);
   // Protect held low while idle guards the array against stray strobes
   assign nandWpN = (state != sIdle);
   assign nandCle = state inside {sCmd, sCmd2, sStCmd};
   assign nandAle = (state == sAddr);
   assign nandWeN = !(writing && phase);
   assign nandReN = !(reading && phase);
   assign nandIoOe = writing;

   // ************************************************************
   // Clock divider and pin synchronisers
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         divCnt <= '0;
         phase  <= 1'b0;
      end else begin
         divCnt <= tick ? '0 : DW'(divCnt + 1'b1);
         if (step) phase <= !phase;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         {ioS1, ioS2, ioS3}    <= '0;
         {rbS1, rbS2, rbS3}    <= '0;
         rbReady               <= 1'b0;
      end else begin
         {ioS1, ioS2, ioS3} <= {nandIoIn, ioS1, ioS2};
         {rbS1, rbS2, rbS3} <= {nandReadyBusy, rbS1, rbS2};
         if (rbS2 == rbS3) rbReady <= rbS3;
      end
   end

   // Bus byte is set up half a strobe period before the write edge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) nandIoOut <= PAD_BYTE;
      else if (!phase) nandIoOut <= nextIo;
   end

   // ************************************************************
   // Bad-block and page-order tables
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         badMap   <= '0;
         usedMap  <= '0;
         badCount <= '0;
         for (int i = 0; i < NUM_BLOCKS; i++) begin
            lastPage[i] <= '0;
            partCnt[i]  <= '0;
         end
      end else begin
         if (markBad && !badMap[curBlock]) begin
            badMap[curBlock] <= 1'b1;                              // see [RQ7]
            badCount         <= (BB+1)'(badCount + 1'b1);
         end
         if (accept && !rejectOp && opKind == OP_PROGRAM) begin
            usedMap[opBlock]  <= 1'b1;
            lastPage[opBlock] <= opPage;
            partCnt[opBlock]  <= (sameUsed && opPage == lastPage[opBlock]) ?
                                 3'(partCnt[opBlock] + 1'b1) : 3'h1;   // see [RQ1]
         end
         if (eraseOk) begin
            usedMap[curBlock]  <= 1'b0;
            lastPage[curBlock] <= '0;
            partCnt[curBlock]  <= '0;
         end
      end
   end

   // ************************************************************
   // Operation sequencer
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= sIdle;
         {curKind, curBlock, curPage, curPartial, curSeg} <= '0;
         {addrIdx, byteCnt, waitCnt, searchCnt} <= '0;
         {doneValid, doneFail, doneReject, reloadReq, scanDone} <= '0;
         spareBlock <= '0;
      end else begin
         doneValid <= 1'b0;
         reloadReq <= 1'b0;
         case (state)
            sIdle: if (accept) begin
               {doneFail, doneReject} <= 2'b00;
               curKind    <= opKind;
               curBlock   <= (opKind == OP_SCAN) ? '0 : opBlock;
               curPage    <= (opKind == OP_SCAN) ? '0 : opPage;
               curPartial <= opPartial;
               curSeg     <= opSegment;
               if (rejectOp) begin                              // see [RQ3] [RQ7]
                  doneReject <= 1'b1;
                  state      <= sDone;
               end else begin
                  if (opKind == OP_SCAN) scanDone <= 1'b0;
                  state <= sCmd;
               end
            end
            sCmd: if (cycleEnd) begin
               addrIdx <= (curKind == OP_ERASE) ? ADDR_FIRST_ROW : ADDR_FIRST_FULL;
               state   <= sAddr;
            end
            sAddr: if (cycleEnd) begin
               byteCnt <= '0;
               addrIdx <= 3'(addrIdx + 1'b1);
               if (addrIdx == ADDR_LAST) state <= isProg ? sWrite : sCmd2;
            end
            sWrite: if (cycleEnd) begin
               byteCnt <= BC'(byteCnt + 1'b1);
               if (byteCnt == LAST_BYTE) state <= sCmd2;
            end
            sCmd2: if (cycleEnd) begin
               waitCnt <= '0;
               state   <= sWaitB;
            end
            sWaitB: begin
               waitCnt <= 8'(waitCnt + 1'b1);
               if (waitCnt >= 8'(WB_CYCLES + SYNC_LAG)) state <= sWaitR;
            end
            sWaitR: if (rbReady) begin
               byteCnt <= '0;
               state   <= (curKind inside {OP_READ, OP_SCAN}) ? sRead : sStCmd;
            end
            sStCmd: if (cycleEnd) state <= sStRead;
            sStRead: if (cycleEnd) begin
               doneFail <= statFail;
               if (statFail && isProg) begin                     // see [RQ10]
                  searchCnt <= '0;
                  state     <= sSpare;
               end else begin
                  state <= sDone;
               end
            end
            sRead: if (cycleEnd) begin
               byteCnt <= BC'(byteCnt + 1'b1);
               if (isScan) begin
                  if (curBlock == LAST_BLOCK) begin             // see [RQ4]
                     scanDone <= 1'b1;
                     state    <= sDone;
                  end else begin
                     curBlock <= BB'(curBlock + 1'b1);
                     state    <= sCmd;
                  end
               end else if (byteCnt == LAST_BYTE) begin
                  state <= sDone;
               end
            end
            // Search resumes from the last spare so replacements rotate
            sSpare: begin
               if (spareOk) begin                               // see [RQ15]
                  reloadReq <= 1'b1;
                  state     <= sDone;
               end else begin
                  spareBlock <= BB'(spareBlock + 1'b1);
                  searchCnt  <= BB'(searchCnt + 1'b1);
                  if (searchCnt == LAST_BLOCK) state <= sDone;
               end
            end
            sDone: begin
               doneValid <= 1'b1;
               state     <= sIdle;
            end
            default: state <= sIdle;
         endcase
      end
   end

   // ************************************************************
   // Read data path and ECC watch
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         {rdData, rdValid, rdUnitEnd, rewriteAdvice, wornOut} <= '0;
      end else begin
         rdValid   <= (state == sRead) && cycleEnd && !isScan;
         rdUnitEnd <= (state == sRead) && cycleEnd && !isScan && (&byteCnt[UW-1:0]);
         if ((state == sRead) && cycleEnd) rdData <= ioS3;
         // Correctable errors only advise a rewrite, never retire
         rewriteAdvice <= eccValid && eccCorrected >= 4'(ECC_WARN);   // see [RQ12] [RQ13] [RQ14]
         wornOut <= int'(badCount) > MAX_RETIRED;                     // see [RQ8]
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_no_erase_bad: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ3]
      (state == sCmd && curKind == OP_ERASE) |-> !badMap[curBlock])
      else $error("erase issued to bad block");
   a_pad_ones: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ2] [RQ16]
      (state == sWrite && !inSeg && !nandWeN) |-> nandIoOut == PAD_BYTE)
      else $error("segment padding not all ones");
   a_scan_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ4]
      (state == sIdle && accept && opKind != OP_SCAN && !scanDone) |=> doneReject)
      else $error("access taken before scan");
   a_scan_marks: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ6]
      scanBad |=> badMap[$past(curBlock)])
      else $error("zero mark not recorded");
   a_partial_limit: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ1]
      (accept && !rejectOp && opKind == OP_PROGRAM) |=> partCnt[$past(opBlock)] <= MAX_PARTIAL)
      else $error("partial program count exceeded");
   a_page_order: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ19]
      (accept && opKind == OP_PROGRAM && sameUsed && opPage < lastPage[opBlock]) |=> doneReject)
      else $error("descending page program taken");
   a_status_fail: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ9] [RQ11]
      statFail |=> badMap[$past(curBlock)] && doneFail)
      else $error("failed block not retired");
   a_status_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ17]
      (state == sStCmd && !nandWeN) |-> nandCle && nandIoOut == CMD_STATUS)
      else $error("status command wrong");
   a_spare_good: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ10]
      reloadReq |-> !badMap[spareBlock] && spareBlock != curBlock ##1 doneValid)
      else $error("replacement block not good");
   a_ecc_keep: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [RQ14]
      (eccValid && !markBad) |=> badCount == $past(badCount))
      else $error("ECC event retired a block");

endmodule

// file: verification/flash_model.sv
// Behavioural flash memory answering the block manager on its parallel port
module flash_model #(
   parameter int NB  = 8,
   parameter int PB  = 8,
   parameter int PGB = 2
) (
   input  logic          sys_clk,
   input  logic          nandCeN,
   input  logic          nandCle,
   input  logic          nandAle,
   input  logic          nandWeN,
   input  logic          nandReN,
   input  logic [7:0]    nandIoOut,
   input  logic [NB-1:0] badMap,     // Never above twenty blocks
   input  logic          failNext,
   output logic [7:0]    nandIoIn,
   output logic          nandReadyBusy
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W  = PB + 1;
   localparam int PW = W << PGB;
   logic [7:0]  mem [NB*PW];
   logic [7:0]  pbuf [W];
   logic [39:0] addr = '0;
   logic [15:0] col = '0;
   logic [3:0]  busyCnt = '0;
   logic        weQ = 1'b1, reQ = 1'b1, stMode = 1'b0, fail = 1'b0;
   logic        cleQ = 1'b0, aleQ = 1'b0, ceQ = 1'b1;
   wire  [39:0] nextAddr = {nandIoOut, addr[39:8]};
   wire  [23:0] row = addr[39:16];
   wire  [23:0] blk = row >> PGB;
   // Mark shows on every page of a bad block
   wire  [7:0]  outByte = stMode ? {7'h70, fail} :
                badMap[blk] ? 8'h00 : mem[row*W+col];
   // Released bus shows the inverse so a stale byte never passes
   assign nandIoIn = (!nandCeN && !nandReN) ? outByte : ~outByte;
   assign nandReadyBusy = (busyCnt == 4'h0);
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // Strobe edges and latch enables are seen one clock late, as they stood
   always @(posedge sys_clk) begin
      weQ <= nandWeN;
      reQ <= nandReN;
      cleQ <= nandCle;
      aleQ <= nandAle;
      ceQ <= nandCeN;
      if (busyCnt != 4'h0) busyCnt <= busyCnt - 4'h1;
      if (nandReN && !reQ && !ceQ) col <= col + 16'h1;
      if (nandWeN && !weQ && !ceQ) begin
         if (aleQ) begin
            addr <= nextAddr;
            col <= nextAddr[15:0];
         end else if (cleQ) begin
            stMode <= (nandIoOut == 8'h70);
            fail <= failNext;
            if (nandIoOut == 8'h80) foreach (pbuf[i]) pbuf[i] = 8'hFF;
            if (nandIoOut == 8'h10) foreach (pbuf[i]) mem[row*W+i] &= pbuf[i];
            if (nandIoOut == 8'hD0 && !failNext) for (int i = 0; i < PW; i++) mem[blk*PW+i] = 8'hFF;
            // Busy length varies by page, so both quick and slow answers occur
            if (nandIoOut inside {8'h10, 8'h30, 8'hD0}) busyCnt <= 4'(row % 5) + 4'h1;
         end else begin
            pbuf[col] <= nandIoOut;
            col <= col + 16'h1;
         end
      end
   end
endmodule

// file: verification/nand_block_management_tb_top.sv
// Self-checking bench for the flash block manager against the flash model
module nand_block_management_tb_top import nand_mgmt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0, rst_n = 1'b0, opValid = 1'b0, opPartial = 1'b0;
   logic        wrValid = 1'b0, eccValid = 1'b0, failNext = 1'b0, gotReload;
   op_kind_type opKind = OP_READ;
   logic [2:0]  opBlock = 3'h0, spareBlock;
   logic [1:0]  opPage = 2'h0, opSegment = 2'h0;
   logic [3:0]  eccCorrected = 4'h0, badCount;
   logic [7:0]  wrData = 8'hFF, badMap = 8'h28, rdData, nandIoOut, nandIoIn;
   logic        opReady, wrReady, rdValid, rdUnitEnd, rewriteAdvice, doneValid, doneFail;
   logic        doneReject, reloadReq, scanDone, wornOut, nandCeN, nandCle, nandAle;
   logic        nandWeN, nandReN, nandWpN, nandIoOe, nandReadyBusy;
   logic [31:0] seed = 32'h95D9D73B;
   logic [7:0]  pg [4][8];
   logic [7:0]  wq [$];
   logic [7:0]  rq [$];
   int          errors = 0;
   int          check_count = 0;
   nand_block_manager #(.NUM_BLOCKS(8), .PAGE_BITS(2), .PAGE_BYTES(8), .ECC_WARN(6))
      i_nand_block_manager (.*);
   flash_model i_flash_model (.*);
   always #50 sys_clk = ~sys_clk;
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      check_count++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Block 1 contents are tracked in pg; a program ANDs into flash like the cells
   task automatic doOp(input op_kind_type k, input int b, p, s, input logic pt, rj, fl);
      int n;
      int ue;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = (pt && i / 2 != s) ? 8'hFF : rnd();
         if (k == OP_PROGRAM && !(pt && i / 2 != s)) wq.push_back(d);
         if (k == OP_PROGRAM && b == 1 && !rj) pg[p][i] &= d;
      end
      @(negedge sys_clk);
      opKind = k;
      {opBlock, opPage, opSegment, opPartial} = {3'(b), 2'(p), 2'(s), pt};
      opValid = 1'b1;
      rq = {};
      ue = 0;
      gotReload = 1'b0;
      for (n = 0; n < 9000; n++) begin
         if (wq.size() > 0) wrData = wq[0];
         wrValid = rnd() > 8'h30;
         @(posedge sys_clk);
         if (wrReady && wrValid) void'(wq.pop_front());
         if (rdValid) rq.push_back(rdData);
         if (rdUnitEnd) ue = rq.size();
         if (reloadReq) gotReload = 1'b1;
         if (doneValid) break;
         @(negedge sys_clk);
         if (!opReady) opValid = 1'b0;
      end
      chk("timeout", 8'h0, 8'(n == 9000));
      if (n == 9000) results();
      chk("reject", 8'(rj), doneReject);
      chk("fail", 8'(fl), doneFail);
      chk("unitEnd", (k == OP_READ && !rj) ? 8'h08 : 8'h00, 8'(ue));
      if (k == OP_READ && b == 1 && !rj) foreach (pg[p][i]) chk("rdData", pg[p][i], rq[i]);
      wq = {};
   endtask
   initial begin
      foreach (pg[i, j]) pg[i][j] = 8'hFF;
      repeat (8) @(negedge sys_clk);
      chk("rstPins", 8'h05, {5'h0, nandCeN, nandWpN, opReady});
      rst_n = 1'b1;
      doOp(OP_READ, 1, 0, 0, 0, 1, 0);
      doOp(OP_SCAN, 0, 0, 0, 0, 0, 0);
      chk("badCount", 8'h2, badCount);
      chk("scanDone", 8'h1, scanDone);
      doOp(OP_ERASE, 3, 0, 0, 0, 1, 0);
      doOp(OP_READ, 5, 2, 0, 0, 1, 0);
      $display("test scan finished");
      doOp(OP_PROGRAM, 1, 0, 0, 0, 0, 0);
      doOp(OP_READ, 1, 0, 0, 0, 0, 0);
      for (int s = 0; s < 4; s++) doOp(OP_PROGRAM, 1, 1, s, 1, 0, 0);
      doOp(OP_PROGRAM, 1, 1, 2, 1, 1, 0);
      doOp(OP_READ, 1, 1, 0, 0, 0, 0);
      doOp(OP_PROGRAM, 1, 0, 0, 0, 1, 0);
      doOp(OP_ERASE, 1, 0, 0, 0, 0, 0);
      foreach (pg[i, j]) pg[i][j] = 8'hFF;
      doOp(OP_READ, 1, 1, 0, 0, 0, 0);
      $display("test program finished");
      failNext = 1'b1;
      doOp(OP_ERASE, 2, 0, 0, 0, 0, 1);
      doOp(OP_PROGRAM, 4, 0, 0, 0, 0, 1);
      failNext = 1'b0;
      chk("reload", 8'h1, gotReload);
      chk("spareBad", 8'h0, 8'(spareBlock inside {[3'h2:3'h5]}));
      doOp(OP_READ, 2, 0, 0, 0, 1, 0);
      doOp(OP_READ, 4, 0, 0, 0, 1, 0);
      doOp(OP_PROGRAM, spareBlock, 0, 0, 0, 0, 0);
      chk("badCount", 8'h4, badCount);
      chk("wornOut", 8'h0, wornOut);
      $display("test failure finished");
      for (int c = 0; c < 16; c++) begin
         @(negedge sys_clk);
         eccCorrected = 4'(c);
         eccValid = 1'b1;
         @(negedge sys_clk);
         eccValid = 1'b0;
         @(posedge sys_clk);
         chk("advice", 8'(c >= 6), rewriteAdvice);
      end
      chk("badCount", 8'h4, badCount);
      $display("test ecc finished");
      results();
   end
endmodule
